/* File: hdl/psir_pkg.sv */
/*
 * shared constants and types of the per-port transceiver status, identifier
 * and advertisement register bank.
 * assumes: one core clock, AHB-Lite word accesses only.
 */
package psir_pkg;

	// port count and bus address layout
	localparam int          PSIR_NPORTS     = 5;
	localparam int          PSIR_AW         = 12;
	localparam int          PSIR_PORT_LSB   = 6;
	localparam int          PSIR_IDX_LSB    = 2;
	localparam logic [2:0]  PSIR_PORT_FIRST = 3'h1;
	localparam logic [2:0]  PSIR_PORT_LAST  = 3'h5;

	// register index within a port window; byte address is four times it
	localparam logic [3:0]  PSIR_IDX_STATUS = 4'h1;
	localparam logic [3:0]  PSIR_IDX_ID_HI  = 4'h2;
	localparam logic [3:0]  PSIR_IDX_ID_LO  = 4'h3;
	localparam logic [3:0]  PSIR_IDX_ADV    = 4'h4;

	// interrupt registers live in the port 0 window
	localparam logic [2:0]  PSIR_PORT_IRQ   = 3'h0;
	localparam logic [3:0]  PSIR_IDX_IRQ_ST = 4'h0;
	localparam logic [3:0]  PSIR_IDX_IRQ_MK = 4'h1;

	// status word constant part: 14:11, 8, 6, 3 and 0 high, 15 low
	localparam logic [15:0] PSIR_STATUS_CONST = 16'h7949;
	localparam int          PSIR_ST_AN_DONE   = 5;
	localparam int          PSIR_ST_RFAULT    = 4;
	localparam int          PSIR_ST_LINK      = 2;
	localparam int          PSIR_ST_JABBER    = 1;

	// advertisement word: writable mask, reset value, pause field position
	localparam logic [15:0] PSIR_ADV_WR_MASK = 16'hADFF;
	localparam logic [15:0] PSIR_ADV_RESET   = 16'h01E1;
	localparam int          PSIR_ADV_PAUSE_LSB = 10;

	// interrupt event bits, four per port
	localparam int          PSIR_EV_PER_PORT = 4;
	localparam int          PSIR_EV_AN_DONE  = 0;
	localparam int          PSIR_EV_RFAULT   = 1;
	localparam int          PSIR_EV_LINK_LOST = 2;
	localparam int          PSIR_EV_JABBER   = 3;
	localparam int          PSIR_EV_W        = PSIR_NPORTS * PSIR_EV_PER_PORT;
	localparam logic [PSIR_EV_W-1:0] PSIR_IRQ_MASK_RESET = '0;

	// strap capture: edges after reset release before the synced strap is used
	localparam logic [1:0]  PSIR_STRAP_SETTLE = 2'h2;

	// AHB transfer types
	localparam logic [1:0]  PSIR_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  PSIR_HTRANS_SEQ    = 2'h3;

	typedef logic [PSIR_NPORTS-1:0] psir_port_t;

	// whole block state
	typedef struct packed {
		logic [PSIR_NPORTS-1:0][15:0] adv;
		psir_port_t                   rf_lat;
		psir_port_t                   jab_lat;
		psir_port_t                   link_down_lat;
		psir_port_t                   an_prev;
		psir_port_t                   rf_prev;
		psir_port_t                   link_prev;
		psir_port_t                   jab_prev;
		logic [PSIR_EV_W-1:0]         irq_stat;
		logic [PSIR_EV_W-1:0]         irq_mask;
		logic [1:0]                   strap_s1;
		logic [1:0]                   strap_s2;
		logic [1:0]                   strap_cnt;
		logic                         strap_done;
		logic                         wr_pend;
		logic [PSIR_AW-1:0]           wr_addr;
		logic [31:0]                  rdata;
	} psir_state_s;

endpackage

/* File: hdl/psir_regs.sv */
/*
 * per-port status, identifier and advertisement registers for five copper
 * transceiver ports, with sticky event interrupt, behind an AHB-Lite slave.
 * assumes: live link/negotiation/fault levels come from logic on the same
 * clock; the pause strap pin is asynchronous and stable around reset.
 */
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - status bit 15 always reads zero
// - status bits 14 to 11 read one
// - status bit 8 reads one, extended status
// - bit 6 one, preamble-less frames accepted
// - bit 5 shows negotiation finished
// - bit 4 latches high on remote fault
// - link latches low; jabber latches high
// - status bit 3 reads one, negotiation able
// - status bit 0 reads one, extended registers
// - two fixed read-only identifier words
// - advert bit 15 writable, resets zero
// - advert bit 13 writable, resets zero
// - advert 11:10 encodes pause ability
// - pause field reset from sampled strap
// - advert bits 14, 12, 9 read zero
// - bits 8:5 reset one, selector 00001
module psir_regs
	import psir_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h0A5A, // arbitrary value
	parameter logic [15:0] ID_LOW  = 16'h5A0A  // arbitrary value
)(
	// clock and reset
	input  wire logic                             I_CLOCK,
	input  wire logic                             I_RST_N,
	// AHB-Lite slave
	input  wire logic                             I_HSEL,
	input  wire logic [psir_pkg::PSIR_AW-1:0]     I_HADDR,
	input  wire logic [1:0]                       I_HTRANS,
	input  wire logic                             I_HWRITE,
	input  wire logic [2:0]                       I_HSIZE,
	input  wire logic [31:0]                      I_HWDATA,
	input  wire logic                             I_HREADY,
	output logic      [31:0]                      O_HRDATA,
	output logic                                  O_HREADYOUT,
	output logic                                  O_HRESP,
	// live transceiver conditions, one bit per port
	input  wire psir_pkg::psir_port_t             I_AN_DONE,
	input  wire psir_pkg::psir_port_t             I_REMOTE_FAULT,
	input  wire psir_pkg::psir_port_t             I_LINK_UP,
	input  wire psir_pkg::psir_port_t             I_JABBER,
	// pause default strap pin
	input  wire logic [1:0]                       I_PAUSE_DEFAULT_STRAP,
	// towards negotiation logic and management interface
	output logic [psir_pkg::PSIR_NPORTS*16-1:0]   O_ADVERT,
	output logic                                  O_MGMT_NO_PREAMBLE_OK,
	// interrupt
	output logic                                  O_IRQ
);
	import psir_pkg::*;

	psir_state_s s_q;
	psir_state_s s_d;

	// address phase qualifiers
	logic                  acc;
	logic                  rd_acc;
	logic [2:0]            a_port;
	logic [3:0]            a_idx;
	logic [2:0]            w_port;
	logic [3:0]            w_idx;
	psir_port_t            rd_status;
	logic                  rd_irq;
	logic [PSIR_EV_W-1:0]  ev;

	// port field of a byte address
	function automatic logic [2:0] port_of(input logic [PSIR_AW-1:0] a);
		port_of = a[PSIR_PORT_LSB +: 3];
	endfunction

	// register index of a byte address
	function automatic logic [3:0] idx_of(input logic [PSIR_AW-1:0] a);
		idx_of = a[PSIR_IDX_LSB +: 4];
	endfunction

	// true for ports 1 to 5, the transceiver windows
	function automatic logic port_ok(input logic [2:0] p);
		port_ok = (p >= PSIR_PORT_FIRST) && (p <= PSIR_PORT_LAST);
	endfunction

	// status word seen by software: constants plus live and latched bits
	function automatic logic [15:0] status_word(
		input logic an, input logic rf, input logic lk, input logic jb);
		logic [15:0] w;
		w                 = PSIR_STATUS_CONST;
		w[PSIR_ST_AN_DONE] = an;
		w[PSIR_ST_RFAULT]  = rf;
		w[PSIR_ST_LINK]    = lk;
		w[PSIR_ST_JABBER]  = jb;
		status_word       = w;
	endfunction

	// one access is taken per cycle in which the bus is ready, we are selected and HTRANS is NONSEQ or SEQ
	assign acc    = I_HSEL && I_HREADY && ((I_HTRANS == PSIR_HTRANS_NONSEQ) || (I_HTRANS == PSIR_HTRANS_SEQ));
	assign rd_acc = acc && !I_HWRITE;
	assign a_port = port_of(I_HADDR);
	assign a_idx  = idx_of(I_HADDR);
	assign w_port = port_of(s_q.wr_addr);
	assign w_idx  = idx_of(s_q.wr_addr);
	assign rd_irq = rd_acc && (a_port == PSIR_PORT_IRQ) && (a_idx == PSIR_IDX_IRQ_ST);

	// read strobe of each port's status register clears its latches
	always_comb
	begin
		for (int p = 0; p < PSIR_NPORTS; p++)
		begin
			rd_status[p] = rd_acc && (a_port == 3'(p + 1)) && (a_idx == PSIR_IDX_STATUS);
		end
	end

	// edge events that feed the sticky interrupt bits
	always_comb
	begin
		for (int p = 0; p < PSIR_NPORTS; p++)
		begin
			ev[p*PSIR_EV_PER_PORT + PSIR_EV_AN_DONE]   = I_AN_DONE[p] && !s_q.an_prev[p];
			ev[p*PSIR_EV_PER_PORT + PSIR_EV_RFAULT]    = I_REMOTE_FAULT[p] && !s_q.rf_prev[p];
			ev[p*PSIR_EV_PER_PORT + PSIR_EV_LINK_LOST] = !I_LINK_UP[p] && s_q.link_prev[p];
			ev[p*PSIR_EV_PER_PORT + PSIR_EV_JABBER]    = I_JABBER[p] && !s_q.jab_prev[p];
		end
	end

	// next state: strap, pending write, latches, interrupt, then read data
	always_comb
	begin
		logic [15:0] wv;
		logic [15:0] rv;
		int          pi;
		s_d = s_q;
		wv  = I_HWDATA[15:0];
		rv  = 16'h0000;
		pi  = 0;

		// strap passes two flops, then loads the pause field once
		s_d.strap_s1 = I_PAUSE_DEFAULT_STRAP;
		s_d.strap_s2 = s_q.strap_s1;
		if (!s_q.strap_done)
		begin
			if (s_q.strap_cnt == PSIR_STRAP_SETTLE)
			begin
				s_d.strap_done = 1'b1;
				for (int p = 0; p < PSIR_NPORTS; p++)
				begin
					s_d.adv[p][PSIR_ADV_PAUSE_LSB +: 2] = s_q.strap_s2;
				end
			end
			else
			begin
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			end
		end

		// data phase of a write; a write after the strap load wins over it
		if (s_q.wr_pend)
		begin
			if (port_ok(w_port) && (w_idx == PSIR_IDX_ADV))
			begin
				pi = int'(w_port) - 1;
				// reserved and ability-9 bits never take a write
				s_d.adv[pi] = (s_d.adv[pi] & ~PSIR_ADV_WR_MASK) | (wv & PSIR_ADV_WR_MASK);
			end
			else if ((w_port == PSIR_PORT_IRQ) && (w_idx == PSIR_IDX_IRQ_MK))
			begin
				// mask is wider than the 16-bit register word, take it from the full bus word
				s_d.irq_mask = I_HWDATA[PSIR_EV_W-1:0];
			end
		end

		// latches: a new condition wins over the clear of a read in the same cycle
		for (int p = 0; p < PSIR_NPORTS; p++)
		begin
			s_d.rf_lat[p]        = I_REMOTE_FAULT[p] || (s_q.rf_lat[p] && !rd_status[p]);
			s_d.jab_lat[p]       = I_JABBER[p] || (s_q.jab_lat[p] && !rd_status[p]);
			s_d.link_down_lat[p] = !I_LINK_UP[p] || (s_q.link_down_lat[p] && !rd_status[p]);
		end
		s_d.an_prev   = I_AN_DONE;
		s_d.rf_prev   = I_REMOTE_FAULT;
		s_d.link_prev = I_LINK_UP;
		s_d.jab_prev  = I_JABBER;

		// sticky events, cleared by reading the interrupt status register; set wins
		s_d.irq_stat = ev | (s_q.irq_stat & ~{PSIR_EV_W{rd_irq}});

		// address phase: latch write target, build read data from fresh advert
		s_d.wr_pend = acc && I_HWRITE;
		if (acc && I_HWRITE)
		begin
			s_d.wr_addr = I_HADDR;
		end
		if (rd_acc)
		begin
			if (port_ok(a_port))
			begin
				pi = int'(a_port) - 1;
				unique case (a_idx)
					PSIR_IDX_STATUS:
						rv = status_word(I_AN_DONE[pi],
							I_REMOTE_FAULT[pi] || s_q.rf_lat[pi],
							I_LINK_UP[pi] && !s_q.link_down_lat[pi],
							I_JABBER[pi] || s_q.jab_lat[pi]);
					PSIR_IDX_ID_HI: rv = ID_HIGH;
					PSIR_IDX_ID_LO: rv = ID_LOW;
					PSIR_IDX_ADV:   rv = s_d.adv[pi];
					default:        rv = 16'h0000;
				endcase
				s_d.rdata = {16'h0000, rv};
			end
			else if ((a_port == PSIR_PORT_IRQ) && (a_idx == PSIR_IDX_IRQ_ST))
			begin
				s_d.rdata = 32'(s_q.irq_stat);
			end
			else if ((a_port == PSIR_PORT_IRQ) && (a_idx == PSIR_IDX_IRQ_MK))
			begin
				s_d.rdata = 32'(s_d.irq_mask);
			end
			else
			begin
				s_d.rdata = 32'h0000_0000; // unmapped reads as zero
			end
		end
	end

	// state register; strap stage resets to a constant, pin sampled after release
	always_ff @(posedge I_CLOCK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			s_q               <= '0;
			s_q.adv           <= {PSIR_NPORTS{PSIR_ADV_RESET}};
			s_q.irq_mask      <= PSIR_IRQ_MASK_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// zero-wait slave, always OKAY
	assign O_HRDATA    = s_q.rdata;
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = 1'b0;

	// outputs towards negotiation logic and management
	assign O_ADVERT              = s_q.adv;
	assign O_MGMT_NO_PREAMBLE_OK = 1'b1;
	assign O_IRQ                 = |(s_q.irq_stat & s_q.irq_mask);

endmodule // psir_regs

/* File: verif/psir_regs_properties.sv */
/* port-level assertions of the status, identifier and advert bank.
   assumes: bound into psir_regs, strap pin steady around reset. */
`timescale 1ns/1ps
module psir_chk
	import psir_pkg::*;
#(
	parameter logic [15:0] ID_HIGH = 16'h0A5A,
	parameter logic [15:0] ID_LOW  = 16'h5A0A
)(
	// clock, reset, bus
	input wire logic         I_CLOCK,
	input wire logic         I_RST_N,
	input wire logic         I_HSEL,
	input wire logic [11:0]  I_HADDR,
	input wire logic [1:0]   I_HTRANS,
	input wire logic         I_HWRITE,
	input wire logic         I_HREADY,
	input wire logic [31:0]  O_HRDATA,
	input wire logic         O_HREADYOUT,
	input wire logic         O_HRESP,
	// live levels and outputs
	input wire psir_port_t   I_AN_DONE,
	input wire psir_port_t   I_REMOTE_FAULT,
	input wire psir_port_t   I_LINK_UP,
	input wire psir_port_t   I_JABBER,
	input wire logic [1:0]   I_PAUSE_DEFAULT_STRAP,
	input wire logic [79:0]  O_ADVERT,
	input wire logic         O_MGMT_NO_PREAMBLE_OK
);
	// read taken at an edge, port window 1..5 only
	wire logic       take = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;
	wire logic       vp   = I_HADDR[8:6] >= PSIR_PORT_FIRST && I_HADDR[8:6] <= PSIR_PORT_LAST && !I_HADDR[11:9];
	wire logic [2:0] pi   = I_HADDR[8:6] - 3'h1;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	sequence st_rd; take && vp && I_HADDR[5:2] == PSIR_IDX_STATUS; endsequence
	sequence id_rd; take && vp && I_HADDR[5:3] == 3'h1; endsequence
	AST_ST_CONST: assert property (st_rd |=> (O_HRDATA[15:0] & 16'hF949) == 16'h7949)
		else $error("status constant bits wrong");
	AST_NOPRE: assert property (O_MGMT_NO_PREAMBLE_OK)
		else $error("preamble-less flag low");
	AST_AN: assert property (st_rd |=> O_HRDATA[5] == $past(I_AN_DONE[pi]))
		else $error("negotiation done bit wrong");
	AST_RF: assert property (st_rd ##0 I_REMOTE_FAULT[pi] |=> O_HRDATA[4])
		else $error("remote fault not shown");
	AST_LINK: assert property (st_rd ##0 !I_LINK_UP[pi] |=> !O_HRDATA[2])
		else $error("link shown up while down");
	AST_JAB: assert property (st_rd ##0 I_JABBER[pi] |=> O_HRDATA[1])
		else $error("jabber not shown");
	AST_ID: assert property (id_rd |=> O_HRDATA == {16'h0000, $past(I_HADDR[2]) ? ID_LOW : ID_HIGH})
		else $error("identifier word wrong");
	AST_RSVD: assert property ((O_ADVERT & {5{16'h5200}}) == 80'h0)
		else $error("advert reserved bit set");
	AST_RST_ADV: assert property ($rose(I_RST_N) |-> O_ADVERT == {5{16'h01E1}})
		else $error("advert reset value wrong");
	AST_STRAP: assert property ($rose(I_RST_N) |-> ##3 O_ADVERT[11:10] == I_PAUSE_DEFAULT_STRAP)
		else $error("pause strap not loaded");
	AST_BUS_OKAY: assert property (O_HREADYOUT && !O_HRESP)
		else $error("slave stalled or answered error");
endmodule // psir_chk

bind psir_regs psir_chk #(.ID_HIGH(ID_HIGH), .ID_LOW(ID_LOW)) u_chk (
	.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
	.I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
	.O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
	.I_AN_DONE(I_AN_DONE), .I_REMOTE_FAULT(I_REMOTE_FAULT), .I_LINK_UP(I_LINK_UP),
	.I_JABBER(I_JABBER), .I_PAUSE_DEFAULT_STRAP(I_PAUSE_DEFAULT_STRAP), .O_ADVERT(O_ADVERT),
	.O_MGMT_NO_PREAMBLE_OK(O_MGMT_NO_PREAMBLE_OK));

/* File: verif/testbench.sv */
/* self-checking bench of the register bank over AHB-Lite.
   assumes: slave may stall, so every phase waits for ready. */
`timescale 1ns/1ps
module testbench;
	import psir_pkg::*;
	localparam logic [15:0] IDH = 16'hC3C3; // arbitrary value
	localparam logic [15:0] IDL = 16'h3C3C; // arbitrary value
	logic        clock, rst_n, hsel, hwrite, ready, irq;
	logic [11:0] haddr;
	logic [1:0]  htrans, strap;
	logic [31:0] hwdata, hrdata;
	logic [79:0] advert;
	psir_port_t  an, rf, lk, jb;
	int          fails, checks;

	psir_regs #(.ID_HIGH(IDH), .ID_LOW(IDL)) i_dut (
		.I_CLOCK(clock), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
		.I_HREADY(ready), .O_HRDATA(hrdata), .O_HREADYOUT(ready), .O_HRESP(),
		.I_AN_DONE(an), .I_REMOTE_FAULT(rf), .I_LINK_UP(lk), .I_JABBER(jb),
		.I_PAUSE_DEFAULT_STRAP(strap), .O_ADVERT(advert),
		.O_MGMT_NO_PREAMBLE_OK(), .O_IRQ(irq));

	// 10 MHz core clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// one single transfer; each phase held until ready seen high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		htrans <= PSIR_HTRANS_NONSEQ;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clock); while (ready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (ready !== 1'b1);
		q = hrdata;
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, {16'h0000, e});
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		xfer(1'b1, a, {16'h0000, d}, q);
	endtask

	function automatic logic [11:0] ad(input int p, input logic [3:0] i);
		return {3'h0, 3'(p), i, 2'h0};
	endfunction

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog at 20000 cycles: tests need well under 2000 cycles
	initial
	begin
		#2000000;
		fails++;
		test_done;
	end

	initial
	begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{an, rf, jb} = '0;
		lk = 5'h1F;
		strap = 2'h3;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		hsel  <= 1'b1;
		// first request no earlier than edge 4, after strap load
		repeat (4) @(posedge clock);
		for (int p = 1; p <= 5; p++)
		begin
			rd(ad(p, PSIR_IDX_STATUS), 16'h794D);
			rd(ad(p, PSIR_IDX_ID_HI), IDH);
			rd(ad(p, PSIR_IDX_ID_LO), IDL);
			rd(ad(p, PSIR_IDX_ADV), 16'h0DE1);
		end
		wr(ad(1, PSIR_IDX_ID_HI), 16'hFFFF);
		wr(ad(1, PSIR_IDX_STATUS), 16'h0000);
		rd(ad(1, PSIR_IDX_ID_HI), IDH);
		rd(ad(1, PSIR_IDX_STATUS), 16'h794D);
		rd(12'h03C, 16'h0000);
		$display("test constants done");
		// advert: writable mask, pause codes, port isolation
		wr(ad(2, PSIR_IDX_ADV), 16'hFFFF);
		rd(ad(2, PSIR_IDX_ADV), 16'hADFF);
		chk({16'h0000, advert[15:0]}, 32'h00000DE1);
		for (int c = 0; c < 4; c++)
		begin
			wr(ad(2, PSIR_IDX_ADV), {4'h0, 2'(c), 10'h1E1});
			rd(ad(2, PSIR_IDX_ADV), {4'h0, 2'(c), 10'h1E1});
		end
		chk({16'h0000, advert[31:16]}, 32'h00000DE1);
		wr(ad(2, PSIR_IDX_ADV), 16'h0000);
		rd(ad(2, PSIR_IDX_ADV), 16'h0000);
		$display("test advert done");
		// one-cycle faults and link drop on port 3 must be latched
		@(posedge clock);
		{rf, jb, an} <= {3{5'h04}};
		lk <= 5'h1B;
		@(posedge clock);
		{rf, jb} <= '0;
		lk <= 5'h1F;
		repeat (2) @(posedge clock);
		rd(ad(3, PSIR_IDX_STATUS), 16'h797B);
		rd(ad(3, PSIR_IDX_STATUS), 16'h796D);
		rd(ad(2, PSIR_IDX_STATUS), 16'h794D);
		$display("test latches done");
		// sticky events, read clear, mask
		chk({31'h0, irq}, 32'h0);
		rd(12'h004, 16'h0000);
		rd(12'h000, 16'h0F00);
		rd(12'h000, 16'h0000);
		wr(12'h004, 16'h0100);
		@(posedge clock);
		jb <= 5'h01;
		an <= 5'h00;
		@(posedge clock);
		jb <= 5'h00;
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		an <= 5'h04;
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		rd(12'h000, 16'h0108);
		chk({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		// second reset with another strap
		@(posedge clock);
		rst_n <= 1'b0;
		strap <= 2'h1;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		rd(ad(5, PSIR_IDX_ADV), 16'h05E1);
		rd(ad(2, PSIR_IDX_ADV), 16'h05E1);
		$display("test reset done");
		test_done;
	end
endmodule // testbench
